// file: spcsm_top.sv
`timescale 1ns/1ps
`default_nettype none
module spcsm_top import spcsm_pkg::*; #(
	parameter int WORD_BITS = SPCSM_WORD_BITS,
	parameter int DIV_BITS = SPCSM_DIV_BITS,
	parameter int FIFO_DEPTH = SPCSM_FIFO_DEPTH
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic [DIV_BITS-1:0] i_bit_clock_divider,
	input wire logic i_divider_source_select,
	input wire logic i_tx_clock_direction,
	input wire logic i_tx_sync_direction,
	input wire logic i_rx_clock_direction,
	input wire logic i_rx_sync_direction,
	input wire logic i_tx_sync_polarity,
	input wire logic i_rx_sync_polarity,
	input wire logic [1:0] i_clock_stop_select,
	input wire logic i_tx_clock_polarity,
	input wire logic i_ext_clock_pin,
	input wire logic i_tx_bit_clock_pin,
	output logic o_tx_bit_clock_pin,
	output logic o_tx_bit_clock_oe_n,
	input wire logic i_tx_sync_pin,
	output logic o_tx_sync_pin,
	output logic o_tx_sync_oe_n,
	input wire logic i_rx_sync_pin,
	input wire logic i_serial_in_pin,
	output logic o_serial_out_pin,
	output logic o_serial_out_oe_n,
	input wire logic [WORD_BITS-1:0] i_tx_data,
	input wire logic i_tx_valid,
	output logic o_tx_ready,
	output logic [WORD_BITS-1:0] o_rx_data,
	output logic o_rx_valid,
	output logic o_tx_underrun,
	output logic o_busy,
	output logic o_config_error
);
	localparam int CW = $clog2(WORD_BITS + 1);
	localparam logic [CW-1:0] LAST_BIT = CW'(WORD_BITS);
	localparam logic [DIV_BITS-1:0] SLAVE_DIV = DIV_BITS'(SPCSM_SLAVE_DIV);

	// High phase length in input clock periods; zero setting clamps to one
	function automatic logic [DIV_BITS:0] high_ticks(input logic [DIV_BITS-1:0] d);
		logic [DIV_BITS:0] h;
		h = '0;
		if (d == '0) begin
			h = (DIV_BITS + 1)'(1);
		end else if (!d[0]) begin
			h = {2'b00, d[DIV_BITS-1:1]} + 1'b1;
		end else begin
			h = ({1'b0, d} + 1'b1) >> 1;
		end
		return h;
	endfunction

	// Low phase length; together with the high phase it spans divider plus one, or two periods for a zero setting
	function automatic logic [DIV_BITS:0] low_ticks(input logic [DIV_BITS-1:0] d);
		logic [DIV_BITS:0] l;
		l = '0;
		if (d == '0) begin
			l = (DIV_BITS + 1)'(1);
		end else if (!d[0]) begin
			l = {2'b00, d[DIV_BITS-1:1]};
		end else begin
			l = ({1'b0, d} + 1'b1) >> 1;
		end
		return l;
	endfunction

	spcsm_state_t state;
	logic [DIV_BITS:0] ph_cnt;
	logic [CW-1:0] bit_cnt;
	logic [WORD_BITS-1:0] tx_shift;
	logic [WORD_BITS-1:0] rx_shift;
	logic sel_act;
	logic clk_lvl;
	logic dout;
	logic dout_en;
	logic ext_meta;
	logic ext_sync;
	logic ext_prev;
	logic sclk_meta;
	logic sclk_sync;
	logic sclk_prev;
	logic ssel_meta;
	logic ssel_sync;
	logic ssel_prev;
	logic sdin_meta;
	logic sdin_sync;

	spcsm_stream_if #(.WIDTH(WORD_BITS)) wr_if();
	spcsm_stream_if #(.WIDTH(WORD_BITS)) rd_if();

	spcsm_fifo #(
		.WIDTH(WORD_BITS),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.wr(wr_if.sink),
		.rd(rd_if.source)
	);

	assign wr_if.data = i_tx_data;
	assign wr_if.valid = i_tx_valid;

	// Mode and configuration decode
	wire logic mode_a = (i_clock_stop_select == SPCSM_STOP_HALF_DELAY) &&
		(i_tx_clock_polarity == SPCSM_POL_IDLE_LOW);
	wire logic mode_b = (i_clock_stop_select == SPCSM_STOP_NO_DELAY) &&
		(i_tx_clock_polarity == SPCSM_POL_IDLE_HIGH);
	wire logic mode_ok = mode_a || mode_b;
	wire logic master_cfg = (i_tx_clock_direction == SPCSM_DIR_OUT) &&
		(i_tx_sync_direction == SPCSM_DIR_OUT) &&
		(i_rx_clock_direction == SPCSM_DIR_IN) &&
		(i_rx_sync_direction == SPCSM_DIR_IN);
	wire logic slave_cfg = (i_tx_clock_direction == SPCSM_DIR_IN) &&
		(i_tx_sync_direction == SPCSM_DIR_IN) &&
		(i_divider_source_select == SPCSM_SRC_CPU) &&
		(i_bit_clock_divider == SLAVE_DIV);
	wire logic run_master = mode_ok && master_cfg;
	wire logic run_slave = mode_ok && slave_cfg;
	wire logic idle_lvl = mode_b;

	// Divider input tick: every core cycle or each external clock rise
	wire logic ext_rise = ext_sync && !ext_prev;
	wire logic tick = (i_divider_source_select == SPCSM_SRC_CPU) ? 1'b1 : ext_rise;
	wire logic ph_end = tick && (ph_cnt <= (DIV_BITS + 1)'(1));
	wire logic [DIV_BITS:0] h_len = high_ticks(i_bit_clock_divider);
	wire logic [DIV_BITS:0] l_len = low_ticks(i_bit_clock_divider);

	// Slave-side edges from the synchronised pins
	wire logic sel_raw = (i_tx_sync_pin ^ i_tx_sync_polarity) |
		(i_rx_sync_pin ^ i_rx_sync_polarity);
	wire logic s_rise = sclk_sync && !sclk_prev;
	wire logic s_fall = !sclk_sync && sclk_prev;
	wire logic s_start = run_slave && ssel_sync && !ssel_prev;
	wire logic last_bit = (bit_cnt == LAST_BIT);

	// Master samples on the edge at which its clock pin really rises, not one cycle early
	wire logic m_rise = clk_lvl && !o_tx_bit_clock_pin;
	wire logic [WORD_BITS-1:0] rx_next = {rx_shift[WORD_BITS-2:0], i_serial_in_pin};

	// Frame start and FIFO pop
	wire logic idle = (state == SPCSM_IDLE);
	wire logic m_start = idle && run_master && rd_if.valid;
	wire logic s_take = idle && s_start;
	assign rd_if.ready = m_start || (s_take && rd_if.valid);
	wire logic [WORD_BITS-1:0] load_word = rd_if.valid ? rd_if.data : '0;

	// Two-flop synchronisers
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			ext_meta <= 1'b0;
			ext_sync <= 1'b0;
			ext_prev <= 1'b0;
			sclk_meta <= 1'b0;
			sclk_sync <= 1'b0;
			sclk_prev <= 1'b0;
			ssel_meta <= 1'b0;
			ssel_sync <= 1'b0;
			ssel_prev <= 1'b0;
			sdin_meta <= 1'b0;
			sdin_sync <= 1'b0;
		end else begin
			ext_meta <= i_ext_clock_pin;
			ext_sync <= ext_meta;
			ext_prev <= ext_sync;
			sclk_meta <= i_tx_bit_clock_pin;
			sclk_sync <= sclk_meta;
			sclk_prev <= sclk_sync;
			ssel_meta <= sel_raw;
			ssel_sync <= ssel_meta;
			ssel_prev <= ssel_sync;
			sdin_meta <= i_serial_in_pin;
			sdin_sync <= sdin_meta;
		end
	end

	// Transfer sequencer for both master and slave
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			state <= SPCSM_IDLE;
			ph_cnt <= '0;
			bit_cnt <= '0;
			tx_shift <= '0;
			rx_shift <= '0;
			sel_act <= 1'b0;
			clk_lvl <= 1'b0;
			dout <= 1'b0;
			dout_en <= 1'b0;
			o_rx_data <= '0;
			o_rx_valid <= 1'b0;
			o_tx_underrun <= 1'b0;
		end else begin
			o_rx_valid <= 1'b0;
			o_tx_underrun <= 1'b0;
			case (state)
				SPCSM_IDLE: begin
					clk_lvl <= idle_lvl;
					bit_cnt <= '0;
					if (m_start) begin
						sel_act <= 1'b1;
						tx_shift <= rd_if.data;
						ph_cnt <= h_len;
						state <= SPCSM_LEAD_H;
					end else if (s_take) begin
						tx_shift <= load_word;
						dout <= load_word[WORD_BITS-1];
						dout_en <= 1'b1;
						o_tx_underrun <= !rd_if.valid;
						state <= SPCSM_SLAVE;
					end
				end
				SPCSM_LEAD_H: begin
					if (tick) begin
						ph_cnt <= ph_cnt - 1'b1;
					end
					if (ph_end) begin
						dout <= tx_shift[WORD_BITS-1];
						dout_en <= 1'b1;
						ph_cnt <= l_len;
						clk_lvl <= 1'b0;
						state <= mode_a ? SPCSM_LEAD_L : SPCSM_LOW;
					end
				end
				SPCSM_LEAD_L, SPCSM_LOW: begin
					if (tick) begin
						ph_cnt <= ph_cnt - 1'b1;
					end
					if (ph_end) begin
						clk_lvl <= 1'b1;
						bit_cnt <= bit_cnt + 1'b1;
						ph_cnt <= h_len;
						state <= SPCSM_HIGH;
					end
				end
				SPCSM_HIGH: begin
					if (tick) begin
						ph_cnt <= ph_cnt - 1'b1;
					end
					if (m_rise) begin
						rx_shift <= rx_next;
					end
					if (ph_end) begin
						ph_cnt <= l_len;
						if (last_bit) begin
							clk_lvl <= idle_lvl;
							dout_en <= 1'b0;
							o_rx_data <= m_rise ? rx_next : rx_shift;
							o_rx_valid <= 1'b1;
							state <= SPCSM_TRAIL;
						end else begin
							clk_lvl <= 1'b0;
							tx_shift <= {tx_shift[WORD_BITS-2:0], 1'b0};
							dout <= tx_shift[WORD_BITS-2];
							state <= SPCSM_LOW;
						end
					end
				end
				SPCSM_TRAIL: begin
					if (tick) begin
						ph_cnt <= ph_cnt - 1'b1;
					end
					if (ph_end) begin
						sel_act <= 1'b0;
						state <= SPCSM_IDLE;
					end
				end
				SPCSM_SLAVE: begin
					if (!ssel_sync) begin
						dout_en <= 1'b0;
						state <= SPCSM_IDLE;
					end else if (s_rise && !last_bit) begin
						rx_shift <= {rx_shift[WORD_BITS-2:0], sdin_sync};
						bit_cnt <= bit_cnt + 1'b1;
						if (bit_cnt == LAST_BIT - 1'b1) begin
							o_rx_data <= {rx_shift[WORD_BITS-2:0], sdin_sync};
							o_rx_valid <= 1'b1;
						end
					end else if (s_fall && bit_cnt != '0) begin
						if (last_bit) begin
							dout_en <= dout_en && !mode_a;
						end else begin
							tx_shift <= {tx_shift[WORD_BITS-2:0], 1'b0};
							dout <= tx_shift[WORD_BITS-2];
						end
					end
				end
				default: begin
					state <= SPCSM_IDLE;
				end
			endcase
		end
	end

	// Pin stage: every pin and status output leaves from a flop
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_tx_bit_clock_pin <= 1'b0;
			o_tx_bit_clock_oe_n <= SPCSM_RST_OE_N;
			o_tx_sync_pin <= SPCSM_RST_SYNC_PIN;
			o_tx_sync_oe_n <= SPCSM_RST_OE_N;
			o_serial_out_pin <= 1'b0;
			o_serial_out_oe_n <= SPCSM_RST_OE_N;
			o_tx_ready <= 1'b0;
			o_busy <= 1'b0;
			o_config_error <= 1'b0;
		end else begin
			o_tx_bit_clock_pin <= clk_lvl;
			o_tx_bit_clock_oe_n <= !run_master;
			o_tx_sync_pin <= sel_act ^ i_tx_sync_polarity;
			o_tx_sync_oe_n <= !run_master;
			o_serial_out_pin <= dout;
			o_serial_out_oe_n <= !dout_en;
			o_tx_ready <= wr_if.ready;
			o_busy <= !idle;
			o_config_error <= i_clock_stop_select[1] && !(run_master || run_slave);
		end
	end
endmodule
`default_nettype wire

// file: spcsm_pkg.sv
`default_nettype none
package spcsm_pkg;
	// Core clock
	localparam int SPCSM_CLK_PERIOD_NS = 100;
	localparam int SPCSM_CLK_RATE_HZ = 1000000000 / SPCSM_CLK_PERIOD_NS;
	// Default widths and depths
	localparam int SPCSM_WORD_BITS = 8;
	localparam int SPCSM_DIV_BITS = 8;
	localparam int SPCSM_FIFO_DEPTH = 8;
	// Clock-stop encodings
	localparam logic [1:0] SPCSM_STOP_NO_DELAY = 2'h2;
	localparam logic [1:0] SPCSM_STOP_HALF_DELAY = 2'h3;
	localparam logic SPCSM_POL_IDLE_LOW = 1'h0;
	localparam logic SPCSM_POL_IDLE_HIGH = 1'h1;
	// Direction bits
	localparam logic SPCSM_DIR_OUT = 1'h1;
	localparam logic SPCSM_DIR_IN = 1'h0;
	// Divider input select
	localparam logic SPCSM_SRC_CPU = 1'h1;
	localparam logic SPCSM_SRC_EXT = 1'h0;
	// Slave divider setting
	localparam int SPCSM_SLAVE_DIV = 1;
	// Reset values
	localparam logic SPCSM_RST_SYNC_PIN = 1'h1;
	localparam logic SPCSM_RST_OE_N = 1'h1;
	// Sequencer states
	typedef enum logic [2:0] {
		SPCSM_IDLE = 3'h0,
		SPCSM_LEAD_H = 3'h1,
		SPCSM_LEAD_L = 3'h2,
		SPCSM_LOW = 3'h3,
		SPCSM_HIGH = 3'h4,
		SPCSM_TRAIL = 3'h5,
		SPCSM_SLAVE = 3'h6
	} spcsm_state_t;
endpackage
`default_nettype wire

// file: spcsm_stream_if.sv
`timescale 1ns/1ps
`default_nettype none
interface spcsm_stream_if #(parameter int WIDTH = 8);
	logic [WIDTH-1:0] data;
	logic valid;
	logic ready;
	modport source (output data, output valid, input ready);
	modport sink (input data, input valid, output ready);
endinterface
`default_nettype wire

// file: spcsm_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module spcsm_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input wire logic i_clk,
	input wire logic i_rst,
	spcsm_stream_if.sink wr,
	spcsm_stream_if.source rd
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [AW:0] FULL_CNT = (AW + 1)'(DEPTH);
	localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wptr;
	logic [AW-1:0] rptr;
	logic [AW:0] count;
	logic not_full;

	wire logic push = wr.valid && not_full;
	wire logic pop = rd.ready && (count != '0);
	wire logic [AW:0] next_count = count + (AW + 1)'(push) - (AW + 1)'(pop);

	// Ready comes from a flag register so the top can drive it from a flop
	assign wr.ready = not_full;
	assign rd.valid = (count != '0);
	assign rd.data = mem[rptr];

	// Storage
	always_ff @(posedge i_clk) begin
		if (push) begin
			mem[wptr] <= wr.data;
		end
	end

	// Pointers and occupancy
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			wptr <= '0;
			rptr <= '0;
			count <= '0;
			not_full <= 1'b1;
		end else begin
			if (push) begin
				wptr <= (wptr == LAST_PTR) ? '0 : wptr + 1'b1;
			end
			if (pop) begin
				rptr <= (rptr == LAST_PTR) ? '0 : rptr + 1'b1;
			end
			count <= next_count;
			not_full <= (next_count != FULL_CNT);
		end
	end
endmodule
`default_nettype wire

// file: spcsm_top_chk.sv
`timescale 1ns/1ps
`default_nettype none
module spcsm_top_chk import spcsm_pkg::*; #(
	parameter int DIV_BITS = SPCSM_DIV_BITS
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic [DIV_BITS-1:0] i_bit_clock_divider,
	input wire logic i_divider_source_select,
	input wire logic [1:0] i_clock_stop_select,
	input wire logic o_tx_bit_clock_pin,
	input wire logic o_tx_bit_clock_oe_n,
	input wire logic o_tx_sync_pin,
	input wire logic o_serial_out_oe_n
);
	logic lclk, lsel, tgl, act, half, nodly;
	logic [11:0] dv, eh, el, run, sel;
	logic [3:0] edg;
	// Expected phase widths in core cycles
	assign dv = 12'(i_bit_clock_divider);
	assign eh = dv[0] ? (dv + 12'h1) >> 1 : (dv >> 1) + 12'h1;
	assign el = (dv[0] || dv == 12'h0) ? (dv + 12'h2) >> 1 : dv >> 1;
	assign tgl = o_tx_bit_clock_pin != lclk;
	assign act = !o_tx_bit_clock_oe_n && i_divider_source_select;
	assign half = i_clock_stop_select == SPCSM_STOP_HALF_DELAY;
	assign nodly = i_clock_stop_select == SPCSM_STOP_NO_DELAY;
	// Clock level run length, cycles since select, edges in frame
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			lclk <= 1'h0;
			lsel <= 1'h1;
			run <= 12'h0;
			sel <= 12'h0;
			edg <= 4'h0;
		end else begin
			lclk <= o_tx_bit_clock_pin;
			lsel <= o_tx_sync_pin;
			run <= tgl ? 12'h1 : run + 12'h1;
			sel <= o_tx_sync_pin ? 12'h0 : sel + 12'h1;
			edg <= o_tx_sync_pin ? 4'h0 : edg + 4'(tgl);
		end
	end
	default clocking dcb @(posedge i_clk); endclocking
	default disable iff (i_rst);
	property p_high;
		act && half && !o_tx_sync_pin && tgl && lclk |-> run == eh;
	endproperty
	a_high: assert property (p_high) else $error("high phase width wrong");
	property p_low;
		act && nodly && !o_tx_sync_pin && tgl && !lclk |-> run == el;
	endproperty
	a_low: assert property (p_low) else $error("low phase width wrong");
	property p_lead_half;
		act && half && !o_tx_sync_pin && tgl && !lclk && edg == 4'h0 |-> sel == eh + el;
	endproperty
	a_lead_half: assert property (p_lead_half) else $error("select lead wrong");
	property p_lead_nd;
		act && nodly && !o_tx_sync_pin && tgl && lclk && edg == 4'h0 |-> sel == eh;
	endproperty
	a_lead_nd: assert property (p_lead_nd) else $error("select lead wrong");
	property p_first;
		act && $fell(o_serial_out_oe_n) |-> sel == eh;
	endproperty
	a_first: assert property (p_first) else $error("first bit late or early");
	property p_hold_half;
		act && half && !lsel && o_tx_sync_pin |-> !o_tx_bit_clock_pin && run == el;
	endproperty
	a_hold_half: assert property (p_hold_half) else $error("select hold wrong");
	property p_hold_nd;
		act && nodly && !lsel && o_tx_sync_pin |-> o_tx_bit_clock_pin && run == eh + el;
	endproperty
	a_hold_nd: assert property (p_hold_nd) else $error("select hold wrong");
	property p_float_nd;
		act && nodly && $rose(o_serial_out_oe_n) |-> o_tx_bit_clock_pin && run == eh;
	endproperty
	a_float_nd: assert property (p_float_nd) else $error("data float wrong");
	property p_float_half;
		act && half && $rose(o_serial_out_oe_n) |-> !o_tx_bit_clock_pin && (tgl || run == 12'h1);
	endproperty
	a_float_half: assert property (p_float_half) else $error("data float wrong");
endmodule
bind spcsm_top spcsm_top_chk #(.DIV_BITS(DIV_BITS)) chk (.i_clk, .i_rst, .i_bit_clock_divider,
	.i_divider_source_select, .i_clock_stop_select, .o_tx_bit_clock_pin, .o_tx_bit_clock_oe_n,
	.o_tx_sync_pin, .o_serial_out_oe_n);
`default_nettype wire

// file: spcsm_spi_dev.sv
`timescale 1ns/1ps
`default_nettype none
module spcsm_spi_dev (
	input wire logic i_sclk,
	input wire logic i_sel_n,
	input wire logic i_mosi,
	input wire logic i_mosi_oe_n,
	input wire logic [7:0] i_reply,
	output logic o_miso,
	output logic [7:0] o_got
);
	logic [7:0] sh;
	logic lsl;
	logic lck;
	int n;
	// One process: select edges load or release, clock edges sample and shift
	always @(i_sel_n or i_sclk) begin
		if (i_sel_n !== lsl) begin
			if (i_sel_n === 1'h0) begin
				sh = i_reply;
				n = 0;
				o_miso = sh[7];
			end else begin
				// Released line shows the inverse of its last bit
				o_miso = ~o_miso;
			end
		end else if (i_sel_n === 1'h0 && i_sclk === 1'h1 && lck === 1'h0) begin
			o_got = {o_got[6:0], i_mosi_oe_n ? 1'hx : i_mosi};
			n = n + 1;
		end else if (i_sel_n === 1'h0 && i_sclk === 1'h0 && lck === 1'h1 && n > 0) begin
			sh = sh << 1;
			o_miso = sh[7];
		end
		lsl = i_sel_n;
		lck = i_sclk;
	end
endmodule
`default_nettype wire

// file: spcsm_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module spcsm_top_tb;
	typedef struct {
		logic [1:0] stop;
		logic pol;
		logic [7:0] div;
		logic src;
		logic [7:0] tx;
		logic [7:0] rep;
		logic [7:0] per;
	} spcsm_row_t;
	// Master frames: mode, polarity, divider, source, words, bit period
	spcsm_row_t rows [6] = '{
		'{2'h3, 1'h0, 8'h01, 1'h1, 8'ha5, 8'h3c, 8'h02},
		'{2'h3, 1'h0, 8'h02, 1'h1, 8'h81, 8'h7e, 8'h03},
		'{2'h3, 1'h0, 8'h03, 1'h1, 8'h5a, 8'hc3, 8'h04},
		'{2'h2, 1'h1, 8'h01, 1'h1, 8'h0f, 8'hf0, 8'h02},
		'{2'h2, 1'h1, 8'h04, 1'h1, 8'h96, 8'h69, 8'h05},
		'{2'h3, 1'h0, 8'h01, 1'h0, 8'h33, 8'hcc, 8'h08}
	};
	logic clk, rst, src, txcd, txsd, rxcd, rxsd, txsp, txcp, tsclk, tsel, trsel;
	logic tdin, txv, slv, lsc = 1'h0, unf = 1'h0, ext = 1'h0;
	logic [1:0] stop;
	logic [7:0] div, txd, rep, rxg, per, sv;
	int err_count, checks_done, cyc = 0, lr = 0;
	wire logic osc, sc_oe, osel, sel_oe, dout, d_oe, txr, rxv, und, busy, cerr, miso;
	wire logic [7:0] rxd, got;
	wire logic sclk = sc_oe ? tsclk : osc;
	wire logic selp = sel_oe ? tsel : osel;
	wire logic din = slv ? tdin : miso;
	spcsm_top uut (.i_clk(clk), .i_rst(rst), .i_bit_clock_divider(div),
		.i_divider_source_select(src), .i_tx_clock_direction(txcd), .i_tx_sync_direction(txsd),
		.i_rx_clock_direction(rxcd), .i_rx_sync_direction(rxsd), .i_tx_sync_polarity(txsp),
		.i_rx_sync_polarity(txsp), .i_clock_stop_select(stop), .i_tx_clock_polarity(txcp),
		.i_ext_clock_pin(ext), .i_tx_bit_clock_pin(sclk), .o_tx_bit_clock_pin(osc),
		.o_tx_bit_clock_oe_n(sc_oe), .i_tx_sync_pin(selp), .o_tx_sync_pin(osel),
		.o_tx_sync_oe_n(sel_oe), .i_rx_sync_pin(trsel), .i_serial_in_pin(din),
		.o_serial_out_pin(dout), .o_serial_out_oe_n(d_oe), .i_tx_data(txd), .i_tx_valid(txv),
		.o_tx_ready(txr), .o_rx_data(rxd), .o_rx_valid(rxv), .o_tx_underrun(und),
		.o_busy(busy), .o_config_error(cerr));
	spcsm_spi_dev dev (.i_sclk(osc), .i_sel_n(osel), .i_mosi(dout), .i_mosi_oe_n(d_oe),
		.i_reply(rep), .o_miso(miso), .o_got(got));
	initial begin
		clk = 1'h0;
		forever #50 clk = ~clk;
	end
	// External divider clock, bit period and received word watchers
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc % 2 == 1) ext <= ~ext;
		if (sc_oe === 1'h0 && osc === 1'h1 && lsc === 1'h0) begin
			per <= 8'(cyc - lr);
			lr <= cyc;
		end
		lsc <= osc;
		if (rxv === 1'h1) rxg <= rxd;
		if (und === 1'h1) unf <= 1'h1;
	end
	task automatic end_of_test();
		if (err_count == 0 && checks_done > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] seen);
		checks_done++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic wait_busy(input logic lvl);
		int n;
		n = 0;
		while (busy !== lvl && n < 3000) begin
			@(posedge clk);
			n++;
		end
		if (busy !== lvl) begin
			err_count++;
			end_of_test();
		end
	endtask
	task automatic push(input logic [7:0] w);
		@(posedge clk);
		txd <= w;
		txv <= 1'h1;
		@(posedge clk);
		txv <= 1'h0;
	endtask
	task automatic setm(input logic [1:0] s, input logic p, input logic [7:0] d, input logic c);
		@(posedge clk);
		{stop, txcp, div, src} <= {s, p, d, c};
		{txcd, txsd, rxcd, rxsd, slv} <= 5'h18;
		repeat (3) @(posedge clk);
	endtask
	// Bench acts as master: select, falling edge sets data, rising edge samples
	task automatic sframe(input logic [7:0] w, input logic alt, output logic [7:0] seen);
		seen = 8'h00;
		if (alt) trsel <= 1'h0;
		else tsel <= 1'h0;
		repeat (8) @(posedge clk);
		for (int b = 7; b >= 0; b--) begin
			tsclk <= 1'h0;
			tdin <= w[b];
			repeat (8) @(posedge clk);
			seen[b] = dout;
			tsclk <= 1'h1;
			repeat (8) @(posedge clk);
		end
		// Idle clock level after the last bit; half-delay floats here already
		tsclk <= !stop[0];
		repeat (8) @(posedge clk);
		chk("oe_n before deselect", {7'h0, stop[0]}, {7'h0, d_oe});
		{tsel, trsel} <= 2'h3;
		repeat (8) @(posedge clk);
		chk("slave rx word", w, rxg);
		chk("slave data oe_n", 8'h01, {7'h0, d_oe});
	endtask
	initial begin
		err_count = 0;
		checks_done = 0;
		{rst, src, txcd, txsd, txsp, tsclk, tsel, trsel} = 8'hff;
		{rxcd, rxsd, txcp, tdin, txv, slv} = 6'h00;
		{stop, div, txd, rep} = 26'h3010000;
		repeat (6) @(posedge clk);
		chk("reset select", 8'h03, {6'h0, sel_oe, osel});
		chk("reset data oe_n", 8'h01, {7'h0, d_oe});
		rst <= 1'h0;
		repeat (3) @(posedge clk);
		chk("ready after reset", 8'h01, {7'h0, txr});
		foreach (rows[i]) begin
			setm(rows[i].stop, rows[i].pol, rows[i].div, rows[i].src);
			rep <= rows[i].rep;
			push(rows[i].tx);
			wait_busy(1'h1);
			wait_busy(1'h0);
			repeat (4) @(posedge clk);
			chk("word at slave", rows[i].tx, got);
			chk("word from slave", rows[i].rep, rxg);
			chk("bit period", rows[i].per, per);
			chk("idle select", 8'h01, {7'h0, osel});
			chk("master pin oe_n", 8'h00, {6'h0, sc_oe, sel_oe});
		end
		setm(2'h3, 1'h0, 8'h01, 1'h1);
		txsd <= 1'h0;
		repeat (3) @(posedge clk);
		chk("config error", 8'h01, {7'h0, cerr});
		chk("pin oe_n off", 8'h03, {6'h0, sc_oe, sel_oe});
		for (int i = 0; i < 9; i++) push(8'h10 + 8'(i));
		chk("ready when full", 8'h00, {7'h0, txr});
		txsd <= 1'h1;
		for (int i = 0; i < 8; i++) begin
			wait_busy(1'h1);
			wait_busy(1'h0);
		end
		repeat (40) @(posedge clk);
		chk("last word drained", 8'h17, got);
		chk("ready when drained", 8'h01, {7'h0, txr});
		@(posedge clk);
		{stop, txcp, div, src} <= {2'h2, 1'h1, 8'h02, 1'h1};
		{txcd, txsd, rxcd, rxsd, slv} <= 5'h01;
		repeat (4) @(posedge clk);
		chk("slave divider", 8'h01, {7'h0, cerr});
		div <= 8'h01;
		repeat (4) @(posedge clk);
		chk("slave divider", 8'h00, {7'h0, cerr});
		push(8'hc6);
		sframe(8'h39, 1'h0, sv);
		chk("slave tx word", 8'hc6, sv);
		sframe(8'h5e, 1'h1, sv);
		chk("underrun word", 8'h00, sv);
		chk("underrun flag", 8'h01, {7'h0, unf});
		// Half-delay slave: clock idles low, data floats after the last falling edge
		{stop, txcp, tsclk} <= {2'h3, 1'h0, 1'h0};
		push(8'ha3);
		sframe(8'h4b, 1'h0, sv);
		chk("half-delay slave word", 8'ha3, sv);
		end_of_test();
	end
endmodule
`default_nettype wire
